// >>> design/spfc_consts.vh
// constants for the self-programming flash control block
// assumes inclusion by bare name from the design files
`ifndef SPFC_CONSTS_VH
`define SPFC_CONSTS_VH

`define SPFC_ADDR_CTRL    2'h0
`define SPFC_ADDR_PTR     2'h1
`define SPFC_ADDR_DATA    2'h2
`define SPFC_ADDR_LOCK    2'h3

`define SPFC_BIT_IE       7
`define SPFC_BIT_BUSY     6
`define SPFC_BIT_SIG      5
`define SPFC_BIT_REEN     4
`define SPFC_BIT_LOCK     3
`define SPFC_BIT_PGWR     2
`define SPFC_BIT_PGER     1
`define SPFC_BIT_ARM      0

`define SPFC_CMD_REEN     5'h11
`define SPFC_CMD_LOCK     5'h09
`define SPFC_CMD_PGWR     5'h05
`define SPFC_CMD_PGER     5'h03
`define SPFC_CMD_LOAD     5'h01

`define SPFC_CTRL_RESET   8'h00
`define SPFC_APP_VECTOR   16'h0000
`define SPFC_STORE_WIN    3'h4
`define SPFC_LOAD_WIN     3'h3

`endif

// >>> design/spfc_page_buf.v
// temporary page buffer of one flash page, one word per slot
// assumes writes come from the sequencer on the same clock
`timescale 1ns/10ps
`default_nettype none

module spfc_page_buf #(
  parameter WORD_BITS = 6
) (
  input  wire                 clk,
  input  wire                 reset,
  input  wire                 clear,
  input  wire                 wr,
  input  wire [WORD_BITS-1:0] wr_idx,
  input  wire [15:0]          wr_data,
  input  wire [WORD_BITS-1:0] rd_idx,
  output reg  [15:0]          rd_data
);
  localparam DEPTH = 1 << WORD_BITS;

  reg [15:0] mem   [0:DEPTH-1];
  reg [DEPTH-1:0] valid_r;

  // a cleared slot reads as erased flash
  always @(posedge clk) begin
    if (reset || clear) begin
      valid_r <= {DEPTH{1'b0}};
    end else if (wr) begin
      valid_r[wr_idx] <= 1'b1;
    end
  end

  always @(posedge clk) begin
    if (wr) begin
      mem[wr_idx] <= wr_data;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      rd_data <= 16'hffff;
    end else if (valid_r[rd_idx]) begin
      rd_data <= mem[rd_idx];
    end else begin
      rd_data <= 16'hffff;
    end
  end
endmodule

`default_nettype wire

// >>> design/spfc_ctrl.v
// self-programming flash control: control/status register, arming window,
// page buffer load, erase/write/lock sequencing and read-back of lock, fuse
// and signature bytes.
// assumes an Avalon-MM master, a cpu issuing store/load strobes, and a flash
// macro that acknowledges erase/write/lock with a one-cycle done pulse.
//
// Our own choices: the address map and register access over Avalon-MM.
`include "spfc_consts.vh"
`timescale 1ns/10ps
`default_nettype none

module spfc_ctrl #(
  parameter WORD_BITS  = 6,
  parameter BOOT_ADDR  = 16'h7000,
  parameter STALL_PAGE = 9'h070,
  parameter SIG_BYTE   = 8'h5a
) (
  input  wire        CLK,
  input  wire        RESET,
  input  wire [1:0]  AVS_ADDRESS,
  input  wire        AVS_READ,
  input  wire        AVS_WRITE,
  input  wire [31:0] AVS_WRITEDATA,
  input  wire [3:0]  AVS_BYTEENABLE,
  output reg  [31:0] AVS_READDATA,
  output wire        AVS_WAITREQUEST,
  input  wire        STORE_PROGRAM_INSTR,
  input  wire        LOAD_PROGRAM_INSTR,
  input  wire        GLOBAL_INT_ENABLE,
  input  wire        BOOT_RESET_SELECT_FUSE,
  input  wire [7:0]  FUSE_LOW_BYTE,
  input  wire        FLASH_DONE,
  input  wire        FLASH_READ_RWW,
  output reg  [15:0] RESET_VECTOR,
  output wire        READY_IRQ,
  output wire        CPU_STALL,
  output wire        RWW_READ_BLOCK,
  output reg         FLASH_ERASE,
  output reg         FLASH_WRITE,
  output reg         FLASH_LOCK,
  output reg  [15:0] FLASH_PAGE,
  output reg  [7:0]  FLASH_LOCK_DATA,
  output reg  [7:0]  LOAD_DATA,
  output reg         LOAD_VALID,
  output wire [15:0] BUF_RD_DATA
);
  localparam PAGE_BITS = 16 - WORD_BITS - 1;

  // ==========================================================
  // helpers
  function legal_cmd;
    input [4:0] c;
    begin
      legal_cmd = (c == `SPFC_CMD_REEN) || (c == `SPFC_CMD_LOCK) ||
                  (c == `SPFC_CMD_PGWR) || (c == `SPFC_CMD_PGER) ||
                  (c == `SPFC_CMD_LOAD);
    end
  endfunction

  function [PAGE_BITS-1:0] page_of;
    input [15:0] z;
    begin
      page_of = z[15:WORD_BITS+1];
    end
  endfunction

  // ==========================================================
  // state
  reg        ie_r;
  reg        busy_r;
  reg [4:0]  cmd_r;
  reg        sig_r;
  reg [2:0]  win_r;
  reg        op_r;
  reg        op_stall_r;
  reg        op_rww_r;
  reg        loading_r;
  reg [15:0] ptr_r;
  reg [15:0] data_r;
  reg [7:0]  lock_bits_r;
  reg        rd_pend_r;
  reg        buf_clear;
  reg        rd_wait_r;

  wire arm   = cmd_r[`SPFC_BIT_ARM];
  wire wr_ok = AVS_WRITE && AVS_BYTEENABLE[0];
  wire [7:0] ctrl_rd = {ie_r, busy_r, sig_r, cmd_r};

  // reads wait one cycle so registered data already stands at the accepting edge
  assign AVS_WAITREQUEST = AVS_READ && !rd_wait_r;

  // ==========================================================
  // register bus
  always @(posedge CLK) begin
    if (RESET) begin
      ptr_r  <= 16'h0000;
      data_r <= 16'h0000;
    end else if (AVS_WRITE) begin
      if (AVS_ADDRESS == `SPFC_ADDR_PTR) begin
        if (AVS_BYTEENABLE[0]) ptr_r[7:0]  <= AVS_WRITEDATA[7:0];
        if (AVS_BYTEENABLE[1]) ptr_r[15:8] <= AVS_WRITEDATA[15:8];
      end
      if (AVS_ADDRESS == `SPFC_ADDR_DATA) begin
        if (AVS_BYTEENABLE[0]) data_r[7:0]  <= AVS_WRITEDATA[7:0];
        if (AVS_BYTEENABLE[1]) data_r[15:8] <= AVS_WRITEDATA[15:8];
      end
    end
  end

  always @(posedge CLK) begin
    if (RESET) begin
      AVS_READDATA <= 32'h00000000;
      rd_wait_r    <= 1'b0;
    end else begin
      rd_wait_r <= AVS_READ && !rd_wait_r;
      if (AVS_READ && !rd_wait_r) begin
        case (AVS_ADDRESS)
          `SPFC_ADDR_CTRL: AVS_READDATA <= {24'h000000, ctrl_rd};
          `SPFC_ADDR_PTR:  AVS_READDATA <= {16'h0000, ptr_r};
          `SPFC_ADDR_DATA: AVS_READDATA <= {16'h0000, data_r};
          `SPFC_ADDR_LOCK: AVS_READDATA <= {24'h000000, lock_bits_r};
          default:         AVS_READDATA <= 32'h00000000;
        endcase
      end
    end
  end

  // ==========================================================
  // command arming and execution
  wire ctrl_wr   = wr_ok && (AVS_ADDRESS == `SPFC_ADDR_CTRL);
  wire [4:0] new_cmd = AVS_WRITEDATA[4:0];
  wire cmd_take  = ctrl_wr && legal_cmd(new_cmd) && !op_r;
  wire sig_take  = ctrl_wr && (AVS_WRITEDATA[5:0] == 6'h21) && !op_r;
  wire store_hit = STORE_PROGRAM_INSTR && arm && !op_r && !cmd_take;
  wire in_stall  = page_of(ptr_r) >= STALL_PAGE[PAGE_BITS-1:0];

  always @(posedge CLK) begin
    if (RESET) begin
      ie_r        <= 1'b0;
      busy_r      <= 1'b0;
      cmd_r       <= 5'h00;
      sig_r       <= 1'b0;
      win_r       <= 3'h0;
      op_r        <= 1'b0;
      op_stall_r  <= 1'b0;
      op_rww_r    <= 1'b0;
      loading_r   <= 1'b0;
      lock_bits_r <= 8'hff;
      FLASH_ERASE <= 1'b0;
      FLASH_WRITE <= 1'b0;
      FLASH_LOCK  <= 1'b0;
      FLASH_PAGE  <= 16'h0000;
      FLASH_LOCK_DATA <= 8'hff;
      buf_clear   <= 1'b0;
    end else begin
      FLASH_ERASE <= 1'b0;
      FLASH_WRITE <= 1'b0;
      FLASH_LOCK  <= 1'b0;
      buf_clear   <= 1'b0;
      if (ctrl_wr) begin
        ie_r <= AVS_WRITEDATA[`SPFC_BIT_IE];
      end
      if (sig_take) begin
        sig_r <= 1'b1;
        cmd_r <= 5'h01;
        win_r <= `SPFC_STORE_WIN;
      end else if (cmd_take) begin
        cmd_r <= new_cmd;
        sig_r <= 1'b0;
        win_r <= `SPFC_STORE_WIN;
        if (new_cmd == `SPFC_CMD_REEN && loading_r) begin
          loading_r <= 1'b0;
          buf_clear <= 1'b1;
        end
      end else if (store_hit && sig_r) begin
        cmd_r <= 5'h00;
        sig_r <= 1'b0;
        win_r <= 3'h0;
      end else if (store_hit) begin
        win_r <= 3'h0;
        case (cmd_r)
          `SPFC_CMD_PGER, `SPFC_CMD_PGWR: begin
            op_r       <= 1'b1;
            op_stall_r <= in_stall;
            op_rww_r   <= !in_stall;
            FLASH_PAGE <= {{(16-PAGE_BITS){1'b0}}, page_of(ptr_r)};
            FLASH_ERASE <= cmd_r == `SPFC_CMD_PGER;
            FLASH_WRITE <= cmd_r == `SPFC_CMD_PGWR;
            if (!in_stall) busy_r <= 1'b1;
          end
          `SPFC_CMD_LOCK: begin
            op_r            <= 1'b1;
            FLASH_LOCK      <= 1'b1;
            FLASH_LOCK_DATA <= data_r[7:0];
            lock_bits_r     <= lock_bits_r & (data_r[7:0] | 8'hc0);
          end
          `SPFC_CMD_REEN: begin
            busy_r    <= 1'b0;
            buf_clear <= 1'b1;
            cmd_r     <= 5'h00;
          end
          default: begin
            busy_r    <= 1'b0;
            loading_r <= 1'b1;
            cmd_r     <= 5'h00;
          end
        endcase
      end else if (op_r && FLASH_DONE) begin
        // completion releases the arm and the command bit together
        op_r       <= 1'b0;
        op_stall_r <= 1'b0;
        op_rww_r   <= 1'b0;
        if (cmd_r == `SPFC_CMD_PGWR) begin
          buf_clear <= 1'b1;
          loading_r <= 1'b0;
        end
        cmd_r <= 5'h00;
      end else if (!op_r && win_r != 3'h0) begin
        win_r <= win_r - 3'h1;
        if (win_r == 3'h1) begin
          cmd_r <= 5'h00;
          sig_r <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // load-program read path
  // a load is counted from the fourth-cycle window too; three-cycle limit
  // is kept by requiring at least two cycles of window left
  wire load_arm = arm && !op_r && (win_r >= (`SPFC_STORE_WIN - `SPFC_LOAD_WIN + 3'h1));

  always @(posedge CLK) begin
    if (RESET) begin
      LOAD_DATA  <= 8'h00;
      LOAD_VALID <= 1'b0;
      rd_pend_r  <= 1'b0;
    end else begin
      LOAD_VALID <= 1'b0;
      if (LOAD_PROGRAM_INSTR && load_arm && sig_r) begin
        LOAD_DATA  <= SIG_BYTE;
        LOAD_VALID <= 1'b1;
      end else if (LOAD_PROGRAM_INSTR && load_arm && cmd_r == `SPFC_CMD_LOCK) begin
        LOAD_DATA  <= ptr_r[0] ? lock_bits_r : FUSE_LOW_BYTE;
        LOAD_VALID <= 1'b1;
      end else if (LOAD_PROGRAM_INSTR) begin
        rd_pend_r <= 1'b1;
      end else if (rd_pend_r) begin
        rd_pend_r  <= 1'b0;
        LOAD_DATA  <= ptr_r[0] ? BUF_RD_DATA[15:8] : BUF_RD_DATA[7:0];
        LOAD_VALID <= 1'b1;
      end
    end
  end

  // ==========================================================
  // reset vector, interrupt and stall
  always @(posedge CLK) begin
    if (RESET) begin
      RESET_VECTOR <= `SPFC_APP_VECTOR;
    end else if (!BOOT_RESET_SELECT_FUSE) begin
      RESET_VECTOR <= BOOT_ADDR;
    end else begin
      RESET_VECTOR <= `SPFC_APP_VECTOR;
    end
  end

  assign READY_IRQ      = ie_r && GLOBAL_INT_ENABLE && !arm;
  assign CPU_STALL      = op_stall_r;
  assign RWW_READ_BLOCK = busy_r && FLASH_READ_RWW;

  spfc_page_buf #(
    .WORD_BITS (WORD_BITS)
  ) u_buf (
    .clk     (CLK),
    .reset   (RESET),
    .clear   (buf_clear),
    .wr      (store_hit && !sig_r && cmd_r == `SPFC_CMD_LOAD),
    .wr_idx  (ptr_r[WORD_BITS:1]),
    .wr_data (data_r),
    .rd_idx  (ptr_r[WORD_BITS:1]),
    .rd_data (BUF_RD_DATA)
  );
endmodule

`default_nettype wire

// >>> verification/spfc_chk.sv
// port checker for the self-programming flash control block
// assumes it is bound to spfc_ctrl and sees only its ports
`include "spfc_consts.vh"
`timescale 1ns/10ps
`default_nettype none
// =========================================================
// checker
module spfc_chk #(
  parameter logic [15:0] BOOT_ADDR  = 16'h7000,
  parameter logic [15:0] STALL_PAGE = 16'h0070
) (
  input wire logic        CLK,
  input wire logic        RESET,
  input wire logic [1:0]  AVS_ADDRESS,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic        STORE_PROGRAM_INSTR,
  input wire logic        GLOBAL_INT_ENABLE,
  input wire logic        BOOT_RESET_SELECT_FUSE,
  input wire logic        FLASH_READ_RWW,
  input wire logic [15:0] RESET_VECTOR,
  input wire logic        READY_IRQ,
  input wire logic        CPU_STALL,
  input wire logic        RWW_READ_BLOCK,
  input wire logic        FLASH_ERASE,
  input wire logic        FLASH_WRITE,
  input wire logic        FLASH_LOCK,
  input wire logic [15:0] FLASH_PAGE
);
  logic [2:0] since_r;
  logic       legal_r;
  wire        ctl_wr = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == `SPFC_ADDR_CTRL;
  wire [4:0]  lo     = AVS_WRITEDATA[4:0];
  wire        any_op = FLASH_ERASE || FLASH_WRITE || FLASH_LOCK;
  wire        pg_op  = FLASH_ERASE || FLASH_WRITE;

  // cycles since the last control write, saturating so old arms stay expired
  always @(posedge CLK) begin
    if (RESET) begin
      since_r <= 3'h7;
      legal_r <= 1'b0;
    end else if (ctl_wr) begin
      since_r <= 3'h0;
      legal_r <= !AVS_WRITEDATA[5] && (lo == `SPFC_CMD_REEN || lo == `SPFC_CMD_LOCK ||
                 lo == `SPFC_CMD_PGWR || lo == `SPFC_CMD_PGER || lo == `SPFC_CMD_LOAD);
    end else if (since_r != 3'h7) begin
      since_r <= since_r + 3'h1;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  a_vec_boot: assert property (!RESET && !BOOT_RESET_SELECT_FUSE |=> RESET_VECTOR == BOOT_ADDR)
    else $error("reset vector not boot address");
  a_vec_app: assert property (!RESET && BOOT_RESET_SELECT_FUSE |=> RESET_VECTOR == 16'h0000)
    else $error("reset vector not application address");
  a_block_src: assert property (RWW_READ_BLOCK |-> FLASH_READ_RWW)
    else $error("read block without a section read");
  a_busy_set: assert property (pg_op && FLASH_PAGE < STALL_PAGE ##1 FLASH_READ_RWW |-> RWW_READ_BLOCK)
    else $error("section read not blocked during programming");
  a_stall_set: assert property (pg_op && FLASH_PAGE >= STALL_PAGE |-> ##[0:1] CPU_STALL)
    else $error("cpu not stalled for stalling section");
  a_op_cause: assert property (any_op |-> $past(STORE_PROGRAM_INSTR))
    else $error("flash operation without a store");
  a_arm_window: assert property (STORE_PROGRAM_INSTR && (since_r >= 3'h4 || !legal_r) |=> !any_op)
    else $error("store acted outside a legal arming window");
  a_irq_gate: assert property (READY_IRQ |-> GLOBAL_INT_ENABLE)
    else $error("ready interrupt without global enable");
  a_irq_op: assert property (pg_op |-> !READY_IRQ [*2])
    else $error("ready interrupt while operation runs");

  c_erase: cover property (FLASH_ERASE);
  c_lock: cover property (FLASH_LOCK);
  c_stall: cover property (CPU_STALL);
  c_irq: cover property (READY_IRQ);
endmodule

bind spfc_ctrl spfc_chk #(.BOOT_ADDR(BOOT_ADDR), .STALL_PAGE(STALL_PAGE)) i_chk (
  .CLK(CLK), .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .STORE_PROGRAM_INSTR(STORE_PROGRAM_INSTR), .GLOBAL_INT_ENABLE(GLOBAL_INT_ENABLE),
  .BOOT_RESET_SELECT_FUSE(BOOT_RESET_SELECT_FUSE), .FLASH_READ_RWW(FLASH_READ_RWW),
  .RESET_VECTOR(RESET_VECTOR), .READY_IRQ(READY_IRQ), .CPU_STALL(CPU_STALL),
  .RWW_READ_BLOCK(RWW_READ_BLOCK), .FLASH_ERASE(FLASH_ERASE), .FLASH_WRITE(FLASH_WRITE),
  .FLASH_LOCK(FLASH_LOCK), .FLASH_PAGE(FLASH_PAGE));
`default_nettype wire

// >>> verification/spfc_cpu_model.sv
// cpu-side partner: store/load strobes and the flash macro done pulse
// assumes the bench calls strobe on the shared clock
`timescale 1ns/10ps
`default_nettype none
// =========================================================
// partner
module spfc_cpu_model #(
  parameter int DLY = 6
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic op,
  output var logic  store,
  output var logic  load,
  output var logic  done
);
  int cnt;

  initial begin
    store = 1'b0;
    load = 1'b0;
    done = 1'b0;
    cnt = 0;
  end

  // one-cycle strobe; the bench calls it inside the arming window, except once after it has expired
  task automatic strobe(input logic is_load);
    @(posedge clk);
    if (is_load) load <= 1'b1;
    else store <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    store <= 1'b0;
  endtask

  // flash macro finishes a fixed time after each operation pulse
  always @(posedge clk) begin
    done <= (cnt == 1);
    if (reset) cnt <= 0;
    else if (op) cnt <= DLY;
    else if (cnt > 0) cnt <= cnt - 1;
  end
endmodule
`default_nettype wire

// >>> verification/spfc_ctrl_tb.sv
// self-checking bench for spfc_ctrl with a scoreboard of expected reads
// assumes the checker bind and the cpu partner model are compiled first
`timescale 1ns/10ps
`default_nettype none
// =========================================================
// bench
module spfc_ctrl_tb;
  logic        clk, rst, rden, wren, fuse, gie, readable_during_write_section, st, ld, dn;
  logic        wq, irq, stall, blk, fe, fw, flk, lv;
  logic [1:0]  adr;
  logic [31:0] wdat, rdat, seed;
  logic [15:0] vec, fpage, bufd, d, p;
  logic [7:0]  fl, ldat;
  int          error_cnt, comparisons, cyc;
  logic [7:0]  rq[$];
  logic [7:0]  lq[$];

  spfc_ctrl #(.BOOT_ADDR(16'h6c00)) i_dut (
    .CLK(clk), .RESET(rst), .AVS_ADDRESS(adr), .AVS_READ(rden), .AVS_WRITE(wren),
    .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wq),
    .STORE_PROGRAM_INSTR(st), .LOAD_PROGRAM_INSTR(ld), .GLOBAL_INT_ENABLE(gie),
    .BOOT_RESET_SELECT_FUSE(fuse), .FUSE_LOW_BYTE(fl), .FLASH_DONE(dn), .FLASH_READ_RWW(readable_during_write_section),
    .RESET_VECTOR(vec), .READY_IRQ(irq), .CPU_STALL(stall), .RWW_READ_BLOCK(blk),
    .FLASH_ERASE(fe), .FLASH_WRITE(fw), .FLASH_LOCK(flk), .FLASH_PAGE(fpage),
    .FLASH_LOCK_DATA(), .LOAD_DATA(ldat), .LOAD_VALID(lv), .BUF_RD_DATA(bufd));
  spfc_cpu_model i_cpu (.clk(clk), .reset(rst), .op(fe | fw | flk), .store(st), .load(ld),
    .done(dn));

  always #25 clk = ~clk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [15:0] seen_v, input logic [15:0] exp_v);
    comparisons++;
    if (seen_v !== exp_v) begin
      error_cnt++;
      $display("BAD %0t: saw %h want %h", $time, seen_v, exp_v);
    end
  endtask

  task automatic summarize();
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // one bus cycle; a read notes its expected byte for the monitor
  task automatic bus(input logic w, input logic [1:0] a, input logic [15:0] v);
    @(posedge clk);
    if (!w) rq.push_back(v[7:0]);
    adr <= a;
    wdat <= {16'h0, v};
    wren <= w;
    rden <= !w;
    do @(posedge clk); while (wq !== 1'b0);
    wren <= 1'b0;
    rden <= 1'b0;
  endtask

  task automatic go(input logic is_load, input int n);
    i_cpu.strobe(is_load);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // read data is taken at the edge where waitrequest is sampled low
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rden === 1'b1 && wq === 1'b0) chk({8'h0, rdat[7:0]}, {8'h0, rq.pop_front()});
    if (lv === 1'b1) chk({8'h0, ldat}, {8'h0, lq.pop_front()});
    if (cyc == 3000) begin
      error_cnt++;
      summarize();
    end
  end

  initial begin
    {clk, rden, wren, adr, wdat, error_cnt, comparisons, cyc} = '0;
    {rst, gie, readable_during_write_section} = 3'b111;
    fuse = 1'b0;
    seed = 32'h0edb;
    void'(xs());
    fl = seed[7:0];
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, 2'h0, 16'h0000);
    bus(1'b0, 2'h3, 16'h00ff);
    chk(vec, 16'h6c00);
    void'(xs());
    d = seed[15:0];
    void'(xs());
    p = {9'h012, seed[5:0], 1'b1};
    bus(1'b1, 2'h1, p);
    bus(1'b1, 2'h2, d);
    bus(1'b1, 2'h0, 16'h0001);
    go(1'b0, 3);
    chk(bufd, d);
    bus(1'b1, 2'h0, 16'h0003);
    go(1'b0, 2);
    chk(fpage, {7'h0, p[15:7]});
    bus(1'b0, 2'h0, 16'h0043);
    // re-enable while the erase still runs is refused, so busy stays set
    bus(1'b1, 2'h0, 16'h0011);
    bus(1'b0, 2'h0, 16'h0040);
    bus(1'b1, 2'h1, 16'h0000);
    repeat (12) @(negedge clk);
    chk(fpage, {7'h0, p[15:7]});
    bus(1'b0, 2'h0, 16'h0040);
    bus(1'b1, 2'h1, p);
    bus(1'b1, 2'h0, 16'h0005);
    go(1'b0, 12);
    chk(bufd, 16'hffff);
    bus(1'b1, 2'h0, 16'h0001);
    go(1'b0, 1);
    bus(1'b0, 2'h0, 16'h0000);
    bus(1'b1, 2'h0, 16'h0011);
    repeat (3) @(negedge clk);
    chk(bufd, 16'hffff);
    bus(1'b1, 2'h0, 16'h0007);
    bus(1'b0, 2'h0, 16'h0000);
    bus(1'b1, 2'h0, 16'h0003);
    repeat (5) @(posedge clk);
    go(1'b0, 2);
    bus(1'b0, 2'h0, 16'h0000);
    bus(1'b1, 2'h1, 16'h0001);
    bus(1'b1, 2'h0, 16'h0009);
    lq.push_back(8'hff);
    go(1'b1, 2);
    bus(1'b1, 2'h1, 16'h0000);
    bus(1'b1, 2'h0, 16'h0009);
    lq.push_back(fl);
    go(1'b1, 2);
    bus(1'b1, 2'h2, 16'h00c3);
    bus(1'b1, 2'h0, 16'h0009);
    go(1'b0, 12);
    bus(1'b0, 2'h3, 16'h00c3);
    bus(1'b0, 2'h0, 16'h0000);
    bus(1'b1, 2'h0, 16'h0021);
    lq.push_back(8'h5a);
    go(1'b1, 2);
    bus(1'b1, 2'h0, 16'h0021);
    go(1'b0, 2);
    void'(xs());
    bus(1'b1, 2'h1, {9'h070, seed[6:0]});
    bus(1'b1, 2'h0, 16'h0003);
    go(1'b0, 12);
    bus(1'b0, 2'h0, 16'h0000);
    bus(1'b1, 2'h0, 16'h0080);
    @(negedge clk);
    chk({15'h0, irq}, 16'h0001);
    bus(1'b1, 2'h0, 16'h0081);
    @(negedge clk);
    chk({15'h0, irq}, 16'h0000);
    @(posedge clk);
    gie <= 1'b0;
    fuse <= 1'b1;
    repeat (6) @(negedge clk);
    chk({15'h0, irq}, 16'h0000);
    chk(vec, 16'h0000);
    summarize();
  end
endmodule
`default_nettype wire
